// ### crce_engine.sv
/*
  CRC checksum engine with a plain register port, one byte folded per clock.
  Assumes a single master on mclk whose strobes are one cycle long and never both at once.
*/
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "crce_regs.svh"

module crce_engine (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic busy,
  output logic writeStall
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    crce_pkg::crce_state_t st;
    logic [5:0] mode;
    logic [31:0] sum;
    logic [31:0] shift;
    logic [2:0] left;
    logic [31:0] rdata;
  } crce_state_all_t;

  crce_state_all_t s_q;
  crce_state_all_t s_d;

  logic [31:0] stepOut;
  logic [7:0] feedByte;
  logic [1:0] polySel;
  logic dataWr;
  logic [2:0] wrSteps;
  logic [31:0] shownSum;
  logic [31:0] inData;

  function automatic logic [31:0] rev32(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h00000000;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31 - i];
    end
    return r;
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // result view: reversal within 32 bits for poly field 2'b10 and within 16 bits for every other value, then complement
  function automatic logic [31:0] present(input logic [31:0] v, input logic [5:0] m);
    logic [31:0] r;
    logic [31:0] t;
    logic wide;
    wide = (m[`CRCE_MODE_POLY_LSB +: 2] == 2'b10);
    r = v;
    t = rev32(v);
    if (m[`CRCE_MODE_SUM_REV]) begin
      r = wide ? t : {16'h0000, t[31:16]};
    end
    if (m[`CRCE_MODE_SUM_INV]) begin
      r = wide ? ~r : {16'h0000, ~r[15:0]};
    end
    return r;
  endfunction

  assign polySel = s_q.mode[`CRCE_MODE_POLY_LSB +: 2];
  // low byte first, msb first within each byte by default; input reversal turns the whole write around
  // reversal is done once on the whole write; reversing each byte again would undo it within each byte
  assign feedByte = s_q.shift[7:0];
  assign shownSum = present(s_q.sum, s_q.mode);

  crce_byte_step u_step (
    .polySel(polySel),
    .crcIn(s_q.sum),
    .dataByte(feedByte),
    .crcOut(stepOut)
  );

  always_comb begin
    dataWr = 1'b0;
    wrSteps = `CRCE_STEPS_WORD;
    inData = regWdata;
    case (regAddr)
      `CRCE_OFF_DATA8: begin
        dataWr = regWrite;
        wrSteps = `CRCE_STEPS_BYTE;
        inData = {24'h000000, regWdata[7:0]};
      end
      `CRCE_OFF_DATA16: begin
        dataWr = regWrite;
        wrSteps = `CRCE_STEPS_HALF;
        inData = {16'h0000, regWdata[15:0]};
      end
      `CRCE_OFF_DATA32: begin
        dataWr = regWrite;
        wrSteps = `CRCE_STEPS_WORD;
      end
      default: begin
        dataWr = 1'b0;
      end
    endcase
    if (s_q.mode[`CRCE_MODE_DIN_INV]) begin
      inData = ~inData;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h00000000;
    // stall only covers a new data write landing on a busy engine
    writeStall = (s_q.st == crce_pkg::ST_FEED) && (s_q.left > 3'h1) && dataWr;
    busy = (s_q.st == crce_pkg::ST_FEED);

    case (s_q.st)
      crce_pkg::ST_FEED: begin
        s_d.sum = stepOut;
        s_d.shift = {8'h00, s_q.shift[31:8]};
        s_d.left = s_q.left - 3'h1;
        if (s_q.left == 3'h1) begin
          s_d.st = crce_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.st = crce_pkg::ST_IDLE;
      end
    endcase

    if (regWrite) begin
      case (regAddr)
        `CRCE_OFF_MODE: begin
          s_d.mode = regWdata[`CRCE_MODE_WIDTH - 1:0];
        end
        `CRCE_OFF_SEED: begin
          s_d.sum = regWdata;
          s_d.st = crce_pkg::ST_IDLE;
          s_d.left = 3'h0;
        end
        default: begin
        end
      endcase
    end

    // a data write accepted on the last step chains straight on, giving back-to-back dma
    if (dataWr && !writeStall) begin
      s_d.st = crce_pkg::ST_FEED;
      s_d.shift = s_q.mode[`CRCE_MODE_DIN_REV] ? rev32(inData) >> (6'd32 - {wrSteps, 3'b000}) : inData;
      s_d.left = wrSteps;
    end

    if (regRead) begin
      case (regAddr)
        `CRCE_OFF_MODE: s_d.rdata = {26'h0000000, s_q.mode};
        `CRCE_OFF_SEED: s_d.rdata = s_q.sum;
        `CRCE_OFF_SUM: s_d.rdata = shownSum;
        `CRCE_OFF_STATUS: s_d.rdata = {29'h00000000, s_q.left};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q.st <= crce_pkg::ST_IDLE;
      s_q.mode <= `CRCE_MODE_RST;
      s_q.sum <= `CRCE_SEED_RST;
      s_q.shift <= 32'h00000000;
      s_q.left <= 3'h0;
      s_q.rdata <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdata = s_q.rdata;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_byte_one_cycle: assert property (@(posedge mclk) disable iff (!rstn)
    (regWrite && regAddr == `CRCE_OFF_DATA8 && !writeStall && !busy) |=> busy ##1 !busy || $past(regWrite))
    else $error("byte write not one step");
  chk_half_two_steps: assert property (@(posedge mclk) disable iff (!rstn)
    (regWrite && regAddr == `CRCE_OFF_DATA16 && !writeStall) |=> (s_q.left == 3'h2))
    else $error("halfword not two steps");
  chk_word_four_steps: assert property (@(posedge mclk) disable iff (!rstn)
    (regWrite && regAddr == `CRCE_OFF_DATA32 && !writeStall) |=> busy[*4])
    else $error("word not four steps");
  chk_stall_when_busy: assert property (@(posedge mclk) disable iff (!rstn)
    writeStall |-> (busy && s_q.left > 3'h1))
    else $error("stall while idle");
  chk_seed_loads: assert property (@(posedge mclk) disable iff (!rstn)
    (regWrite && regAddr == `CRCE_OFF_SEED) |=> (s_q.sum == $past(regWdata) && !busy))
    else $error("seed not loaded");
  chk_read_sum_view: assert property (@(posedge mclk) disable iff (!rstn)
    (regRead && regAddr == `CRCE_OFF_SUM) |=> (regRdata == $past(shownSum)))
    else $error("sum read wrong");
  chk_mode_stored: assert property (@(posedge mclk) disable iff (!rstn)
    (regWrite && regAddr == `CRCE_OFF_MODE) |=> (s_q.mode == $past(regWdata[5:0])))
    else $error("mode not stored");
  chk_sum_inverts: assert property (@(posedge mclk) disable iff (!rstn)
    (s_q.mode[`CRCE_MODE_SUM_INV] && !s_q.mode[`CRCE_MODE_SUM_REV] && polySel == 2'b10) |-> (shownSum == ~s_q.sum))
    else $error("sum complement wrong");
  chk_narrow_upper: assert property (@(posedge mclk) disable iff (!rstn)
    (polySel != 2'b10 && busy) |=> (s_q.sum[31:16] == 16'h0000))
    else $error("16-bit sum overflow");
endmodule // crce_engine

// ### crce_regs.svh
/*
  Register offsets, field positions, reset values and step counts of the CRC engine.
  Assumes word-indexed register addresses on a plain strobe port.
*/
`ifndef CRCE_REGS_SVH
`define CRCE_REGS_SVH

// ----------------------------------------
// offsets (word index)
// ----------------------------------------
`define CRCE_OFF_MODE 4'h0
`define CRCE_OFF_SEED 4'h1
`define CRCE_OFF_SUM 4'h2
`define CRCE_OFF_DATA8 4'h3
`define CRCE_OFF_DATA16 4'h4
`define CRCE_OFF_DATA32 4'h5
`define CRCE_OFF_STATUS 4'h6

// ----------------------------------------
// mode fields
// ----------------------------------------
`define CRCE_MODE_POLY_LSB 0
`define CRCE_MODE_DIN_REV 2
`define CRCE_MODE_DIN_INV 3
`define CRCE_MODE_SUM_REV 4
`define CRCE_MODE_SUM_INV 5
`define CRCE_MODE_WIDTH 6

// ----------------------------------------
// reset values and polynomials
// ----------------------------------------
`define CRCE_MODE_RST 6'h00
`define CRCE_SEED_RST 32'h0000FFFF
`define CRCE_POLY_CCITT 32'h00001021
`define CRCE_POLY_CRC16 32'h00008005
`define CRCE_POLY_CRC32 32'h04C11DB7

// ----------------------------------------
// timing
// ----------------------------------------
`define CRCE_STEPS_BYTE 3'h1
`define CRCE_STEPS_HALF 3'h2
`define CRCE_STEPS_WORD 3'h4

`endif

// ### crce_pkg.sv
/*
  Types shared by the CRC engine files.
  Assumes nothing of its surroundings.
*/
package crce_pkg;
  typedef enum logic [1:0] {
    POLY_CCITT = 2'b00,
    POLY_CRC16 = 2'b01,
    POLY_CRC32 = 2'b10
  } crce_poly_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_FEED = 1'b1
  } crce_state_t;
endpackage

// ### crce_byte_step.sv
/*
  One byte step of the CRC shift register, MSB-first over the selected polynomial.
  Assumes the caller presents the byte already reversed or inverted as wanted.
*/
`timescale 1ns/1ps
`include "crce_regs.svh"

module crce_byte_step (
  input wire logic [1:0] polySel,
  input wire logic [31:0] crcIn,
  input wire logic [7:0] dataByte,
  output logic [31:0] crcOut
);
  logic [31:0] poly;
  logic [31:0] topBit;
  logic [31:0] acc;

  always_comb begin
    poly = `CRCE_POLY_CRC32;
    topBit = 32'h80000000;
    case (crce_pkg::crce_poly_t'(polySel))
      crce_pkg::POLY_CCITT: begin
        poly = `CRCE_POLY_CCITT;
        topBit = 32'h00008000;
      end
      crce_pkg::POLY_CRC16: begin
        poly = `CRCE_POLY_CRC16;
        topBit = 32'h00008000;
      end
      default: begin
        poly = `CRCE_POLY_CRC32;
        topBit = 32'h80000000;
      end
    endcase
    acc = crcIn;
    for (int i = 7; i >= 0; i--) begin
      // feedback = crc msb xor data bit, msb of the byte first
      if (((acc & topBit) != 32'h00000000) ^ dataByte[i]) begin
        acc = (acc << 1) ^ poly;
      end else begin
        acc = acc << 1;
      end
    end
    // 16-bit modes keep the upper half clear
    crcOut = (topBit == 32'h80000000) ? acc : {16'h0000, acc[15:0]};
  end
endmodule // crce_byte_step

// ### crce_master.sv
/*
  Bus master model of the engine's register port: programmed or back-to-back writes, and reads.
  Assumes a data write shown while writeStall is high is dropped and must be repeated.
*/
`timescale 1ns/1ps

module crce_master (
  input wire logic mclk,
  input wire logic writeStall,
  input wire logic [31:0] regRdata,
  output logic [3:0] regAddr,
  output logic [31:0] regWdata,
  output logic regWrite,
  output logic regRead
);
  int stalls = 0;

  initial begin
    regAddr = 4'h0;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
  end

  // entered just after a rising edge; leaves the strobe up for back-to-back use
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output bit ok);
    bit st;
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge mclk);
      st = writeStall;
      @(posedge mclk);
      if (st) stalls++; // held and repeated, up to 8 tries in all
      else ok = 1'b1;
    end
  endtask

  // stale data flipped so an engine that samples it off-strobe shows up
  task automatic rel();
    regWrite <= 1'b0;
    regRead <= 1'b0;
    regWdata <= ~regWdata;
  endtask

  task automatic idle();
    rel();
    @(posedge mclk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    regAddr <= a;
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    d = regRdata;
    @(posedge mclk);
  endtask
endmodule // crce_master

// ### crce_engine_tb.sv
/*
  Self-checking bench of the CRC engine with a reference checksum model.
  Assumes the master model in crce_master.sv and the register map of crce_regs.svh.
*/
`timescale 1ns/1ps
`include "crce_regs.svh"

module crce_engine_tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] regAddr;
  logic [31:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [31:0] regRdata;
  logic busy;
  logic writeStall;
  logic [5:0] mode;
  logic [31:0] sum;
  int fails = 0;
  int samples_checked = 0;

  always #50 mclk = ~mclk;

  crce_engine crce_engine_i (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .busy(busy), .writeStall(writeStall));
  crce_master crce_master_i (.mclk(mclk), .writeStall(writeStall), .regRdata(regRdata),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead));

  // ----------------------------------------
  // checking and reference model
  // ----------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rev(input logic [31:0] v, input int n);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < n; i++) r[i] = v[n-1-i];
    return r;
  endfunction

  function automatic logic [31:0] msk(input int n);
    return (n == 32) ? 32'hFFFFFFFF : ((32'h1 << n) - 32'h1);
  endfunction

  function automatic int wid();
    return mode[1] ? 32 : 16;
  endfunction

  task automatic fold(input logic [31:0] d, input int nb);
    logic [31:0] p;
    p = mode[1] ? `CRCE_POLY_CRC32 : (mode[0] ? `CRCE_POLY_CRC16 : `CRCE_POLY_CCITT);
    d = d & msk(8 * nb);
    if (mode[3]) d = d ^ msk(8 * nb);
    if (mode[2]) d = rev(d, 8 * nb);
    for (int b = 0; b < nb; b++) begin
      sum = sum ^ ({24'h0, d[8*b +: 8]} << (wid() - 8));
      for (int k = 0; k < 8; k++) sum = sum[wid()-1] ? ((sum << 1) ^ p) : (sum << 1);
      sum = sum & msk(wid());
    end
  endtask

  task automatic wrt(input logic [3:0] a, input logic [31:0] d, input int nb);
    bit ok;
    crce_master_i.wr(a, d, ok);
    if (!ok) begin
      fails++;
      wrap_up();
    end
    if (nb > 0) fold(d, nb);
  endtask

  task automatic sum_chk();
    logic [31:0] v;
    logic [31:0] got;
    int n;
    // a word may still be stepping; read only once all bytes are folded
    for (n = 0; n < 8; n++) begin
      @(negedge mclk);
      if (!busy) break;
    end
    @(posedge mclk);
    if (n == 8) begin
      fails++;
      wrap_up();
    end
    v = sum;
    if (mode[4]) v = rev(v, wid());
    if (mode[5]) v = v ^ msk(wid());
    crce_master_i.rd(`CRCE_OFF_SUM, got);
    chk(got, v);
  endtask

  task automatic setup(input logic [5:0] m, input logic [31:0] s);
    wrt(`CRCE_OFF_MODE, {26'h0, m}, 0);
    wrt(`CRCE_OFF_SEED, s, 0);
    crce_master_i.idle();
    mode = m;
    sum = s & msk(wid());
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset();
    logic [31:0] got;
    mode = `CRCE_MODE_RST;
    sum = `CRCE_SEED_RST;
    crce_master_i.rd(`CRCE_OFF_SEED, got);
    chk(got, `CRCE_SEED_RST);
    wrt(`CRCE_OFF_DATA8, 32'h0000005A, 1);
    crce_master_i.idle();
    sum_chk();
  endtask

  task automatic s_widths();
    for (int p = 0; p < 3; p++) begin
      setup(6'(p), 32'h5A5AA5C3);
      wrt(`CRCE_OFF_DATA8, 32'h000000C3, 1);
      wrt(`CRCE_OFF_DATA16, 32'h00001234, 2);
      wrt(`CRCE_OFF_DATA32, 32'hDEADBEEF, 4);
      crce_master_i.idle();
      sum_chk();
    end
  endtask

  task automatic s_options();
    for (int p = 0; p < 3; p += 2) begin
      for (int o = 0; o < 16; o++) begin
        setup({4'(o), 2'(p)}, 32'h00C0FFEE);
        wrt(`CRCE_OFF_DATA32, 32'h01020384, 4);
        wrt(`CRCE_OFF_DATA16, 32'h0000F00D, 2);
        crce_master_i.idle();
        sum_chk();
      end
    end
  endtask

  task automatic s_timing();
    for (int n = 1; n <= 4; n *= 2) begin
      wrt(n == 1 ? `CRCE_OFF_DATA8 : (n == 2 ? `CRCE_OFF_DATA16 : `CRCE_OFF_DATA32), 32'h89ABCDEF, n);
      crce_master_i.rel();
      for (int i = 0; i <= n; i++) begin
        @(negedge mclk);
        chk({31'h0, busy}, {31'h0, i < n});
      end
      @(posedge mclk);
    end
    sum_chk();
  endtask

  task automatic s_stall();
    logic [31:0] got;
    int s0;
    setup(6'h02, 32'h12345678);
    crce_master_i.rd(`CRCE_OFF_SEED, got);
    chk(got, 32'h12345678);
    s0 = crce_master_i.stalls;
    wrt(`CRCE_OFF_DATA32, 32'hCAFEF00D, 4);
    wrt(`CRCE_OFF_DATA8, 32'h00000011, 1);
    wrt(`CRCE_OFF_DATA8, 32'h00000022, 1);
    wrt(`CRCE_OFF_DATA8, 32'h00000033, 1);
    crce_master_i.idle();
    chk(32'(crce_master_i.stalls - s0), 32'h3);
    sum_chk();
    crce_master_i.rd(4'hF, got);
    chk(got, 32'h0);
    wrt(4'hF, 32'hFFFFFFFF, 0);
    crce_master_i.idle();
    sum_chk();
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    s_reset();
    s_widths();
    s_options();
    s_timing();
    s_stall();
    wrap_up();
  end
endmodule // crce_engine_tb
